// >>> mlsfc_pkg.sv
package mlsfc_pkg;
    localparam logic [7:0]  CFG_OFFSET    = 8'h94;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;

    localparam int ABN_EN_BIT    = 30;
    localparam int SYNC_EN_BIT   = 29;
    localparam int NOMTR_EN_BIT  = 28;
    localparam int ABN_THR_HI    = 27;
    localparam int ABN_THR_LO    = 24;
    localparam int SYNC_CNT_HI   = 23;
    localparam int SYNC_CNT_LO   = 21;
    localparam int NOMTR_HI      = 20;
    localparam int NOMTR_LO      = 18;
    localparam int OV_MODE_BIT   = 17;
    localparam int MAXV_HI       = 16;
    localparam int MAXV_LO       = 14;
    localparam int UV_MODE_BIT   = 13;
    localparam int MINV_HI       = 12;
    localparam int MINV_LO       = 10;
    localparam int RETRY_HI      = 9;
    localparam int RETRY_LO      = 7;
    localparam int MINSPD_HI     = 6;
    localparam int MINSPD_LO     = 4;
    localparam int RATIO_HI      = 3;
    localparam int RATIO_LO      = 2;
    localparam int DUTY_HI       = 1;
    localparam int DUTY_LO       = 0;

    // abnormal speed threshold in Hz per code step
    localparam logic [11:0] ABN_STEP_HZ   = 12'h0FA;
    localparam logic [3:0]  SYNC_BASE     = 4'h2;
    localparam logic [3:0]  RATIO_STEP    = 4'h2;

    // sense voltage in microvolts
    localparam logic [15:0] NOMTR_UV [8] = '{16'h1388, 16'h1D4C, 16'h2710,
        16'h30D4, 16'h4E20, 16'h61A8, 16'h7530, 16'h9C40};
    // supply limits in tenths of a volt, zero means no limit
    localparam logic [9:0]  MAXV_DV [8] = '{10'h000, 10'h0C8, 10'h0FA,
        10'h12C, 10'h15E, 10'h190, 10'h1F4, 10'h258};
    localparam logic [9:0]  MINV_DV [8] = '{10'h000, 10'h03C, 10'h046,
        10'h050, 10'h05A, 10'h064, 10'h078, 10'h096};
    // retry attempts, zero means unlimited
    localparam logic [4:0]  RETRY_N [8] = '{5'h00, 5'h02, 5'h03, 5'h05,
        5'h07, 5'h0A, 5'h0F, 5'h14};
    // minimum lock speed in tenths of a Hz
    localparam logic [7:0]  MINSPD_DHZ [8] = '{8'h05, 8'h0A, 8'h14, 8'h1E,
        8'h32, 8'h64, 8'h96, 8'hFA};
    // zero-speed duty in tenths of a percent
    localparam logic [4:0]  DUTY_PM [4] = '{5'h0A, 5'h0F, 5'h14, 5'h19};

    localparam logic [3:0]  MODE_RETRY_MIN = 4'h4;
    localparam logic [3:0]  MODE_REPORT    = 4'h8;

    localparam int RETRY_TIME_MS   = 100;
    localparam int CYCLES_PER_MS   = 250000;
    localparam int RETRY_CYCLES_DEF = RETRY_TIME_MS * CYCLES_PER_MS;

    typedef enum logic [1:0] {
        LK_IDLE,
        LK_LATCHED,
        LK_RETRY_WAIT
    } mlsfc_lock_state_t;
endpackage

// >>> mlsfc_lock_gate.sv
`timescale 1ns/10ps
module mlsfc_lock_gate #(
    parameter int N = 3
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [N-1:0] lock_evt,
    input  wire logic [N-1:0] lock_en,
    input  wire logic         cause_clear,
    output logic      [N-1:0] gated_evt_q,
    output logic      [N-1:0] cause_q
);
    import mlsfc_pkg::*;

    if (N < 1) begin : g_chk
        $error("mlsfc_lock_gate needs at least one detector");
    end

    genvar i;
    for (i = 0; i < N; i++) begin : g_det
        // RULE_17: disabled detector masked
        always_ff @(posedge clk) begin
            if (!nrst) begin
                gated_evt_q[i] <= 1'b0;
            end else begin
                gated_evt_q[i] <= lock_evt[i] & lock_en[i];
            end
        end

        // set wins over clear so a cause is never lost
        always_ff @(posedge clk) begin
            if (!nrst) begin
                cause_q[i] <= 1'b0;
            end else if (lock_evt[i] & lock_en[i]) begin
                cause_q[i] <= 1'b1;
            end else if (cause_clear) begin
                cause_q[i] <= 1'b0;
            end
        end

        // RULE_17: gating checked
        property p_gate;
            @(posedge clk) disable iff (!nrst)
            gated_evt_q[i] |-> $past(lock_evt[i]) && $past(lock_en[i]);
        endproperty
        a_gate: assert property (p_gate) // RULE_17
            else $error("gated lock event without enabled source");
    end
endmodule

// >>> mlsfc_cfg.sv
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01: config word at 0x94, 32 bits, all fields zero after reset.
// RULE_02: bit 30 turns abnormal-speed lock detection on or off.
// RULE_03: bit 29 turns loss-of-sync lock detection on or off.
// RULE_04: bit 28 turns no-motor lock detection on or off.
// RULE_05: bits 27:24 give abnormal speed threshold 250 Hz times code plus one.
// RULE_06: bits 23:21 give sync losses before fault: code plus two.
// RULE_07: bits 20:18 pick no-motor sense voltage; current is voltage over gain.
// RULE_08: bit 17 zero latches overvoltage, one auto-clears when back in bounds.
// RULE_09: bits 16:14 pick max supply, code zero means no limit.
// RULE_10: bit 13 zero latches undervoltage, one auto-clears in bounds.
// RULE_11: bits 12:10 pick min supply, code zero means no limit.
// RULE_12: bits 9:7 pick retry attempt limit, code zero unlimited.
// RULE_13: bits 6:4 pick minimum speed below which lock triggers.
// RULE_14: bits 3:2 pick speed jump ratio 2, 4, 6 or 8.
// RULE_15: bits 1:0 pick duty below which target speed is zero.
// RULE_16: on lock, act per response mode: latch, retry, report or ignore.
// RULE_17: a disabled detector never raises lock fault or fault output.
module mlsfc_cfg #(
    parameter int RETRY_CYCLES = mlsfc_pkg::RETRY_CYCLES_DEF
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata_q,
    output logic             reg_rvalid_q,
    input  wire logic        abn_speed_evt,
    input  wire logic        sync_loss_evt,
    input  wire logic        no_motor_evt,
    input  wire logic [3:0]  lock_response_mode,
    input  wire logic        fault_clear,
    input  wire logic [9:0]  supply_dv,
    output logic             abnormal_speed_lock_enable,
    output logic             sync_loss_lock_enable,
    output logic             no_motor_lock_enable,
    output logic      [11:0] abnormal_speed_threshold,
    output logic      [3:0]  sync_loss_count,
    output logic      [15:0] no_motor_current_threshold,
    output logic      [9:0]  max_running_supply,
    output logic      [9:0]  min_running_supply,
    output logic      [4:0]  retry_limit,
    output logic      [7:0]  min_lock_speed,
    output logic      [3:0]  speed_jump_ratio,
    output logic      [4:0]  zero_speed_duty_threshold,
    output logic      [2:0]  lock_cause_q,
    output logic             lock_fault_q,
    output logic             lock_report_q,
    output logic      [1:0]  bridge_action_q,
    output logic             ov_fault_q,
    output logic             uv_fault_q,
    output logic             fault_output_low_q
);
    import mlsfc_pkg::*;

    if (RETRY_CYCLES < 1) begin : g_chk
        $error("RETRY_CYCLES must be at least one");
    end

    logic [31:0]       cfg_q;
    logic [2:0]        gated_evt_q;
    logic              any_evt;
    mlsfc_lock_state_t state_q;
    mlsfc_lock_state_t state_d;
    logic [31:0]       timer_q;
    logic [4:0]        retry_cnt_q;
    logic              timer_done;
    logic              limit_hit;
    logic              ov_now;
    logic              uv_now;
    logic              ov_d;
    logic              uv_d;

    // RULE_01: register write and reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_q <= CFG_RESET;
        end else if (reg_wr && reg_addr == CFG_OFFSET) begin
            cfg_q <= reg_wdata;
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata_q  <= 32'h0000_0000;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd && reg_addr == CFG_OFFSET) begin
                reg_rdata_q <= cfg_q;
            end else begin
                reg_rdata_q <= 32'h0000_0000;
            end
        end
    end

    // RULE_02: enable bits
    assign abnormal_speed_lock_enable = cfg_q[ABN_EN_BIT];
    // RULE_03: enable bits
    assign sync_loss_lock_enable      = cfg_q[SYNC_EN_BIT];
    // RULE_04: enable bits
    assign no_motor_lock_enable       = cfg_q[NOMTR_EN_BIT];

    // decoded values registered, one cycle behind the word
    always_ff @(posedge clk) begin
        if (!nrst) begin
            abnormal_speed_threshold   <= ABN_STEP_HZ;
            sync_loss_count            <= SYNC_BASE;
            no_motor_current_threshold <= NOMTR_UV[0];
            max_running_supply         <= MAXV_DV[0];
            min_running_supply         <= MINV_DV[0];
            retry_limit                <= RETRY_N[0];
            min_lock_speed             <= MINSPD_DHZ[0];
            speed_jump_ratio           <= RATIO_STEP;
            zero_speed_duty_threshold  <= DUTY_PM[0];
        end else begin
            // RULE_05: threshold step
            abnormal_speed_threshold <= 12'((16'(cfg_q[ABN_THR_HI:ABN_THR_LO])
                + 16'h0001) * 16'(ABN_STEP_HZ));
            // RULE_06: loss count
            sync_loss_count <= 4'(cfg_q[SYNC_CNT_HI:SYNC_CNT_LO]) + SYNC_BASE;
            // RULE_07: sense voltage
            no_motor_current_threshold <= NOMTR_UV[cfg_q[NOMTR_HI:NOMTR_LO]];
            // RULE_09: max supply
            max_running_supply <= MAXV_DV[cfg_q[MAXV_HI:MAXV_LO]];
            // RULE_11: min supply
            min_running_supply <= MINV_DV[cfg_q[MINV_HI:MINV_LO]];
            // RULE_12: retry attempts
            retry_limit <= RETRY_N[cfg_q[RETRY_HI:RETRY_LO]];
            // RULE_13: min speed
            min_lock_speed <= MINSPD_DHZ[cfg_q[MINSPD_HI:MINSPD_LO]];
            // RULE_14: jump ratio
            speed_jump_ratio <= 4'((4'(cfg_q[RATIO_HI:RATIO_LO]) + 4'h1)
                * RATIO_STEP);
            // RULE_15: zero duty
            zero_speed_duty_threshold <= DUTY_PM[cfg_q[DUTY_HI:DUTY_LO]];
        end
    end

    mlsfc_lock_gate #(
        .N (3)
    ) mlsfc_lock_gate_inst (
        .clk         (clk),
        .nrst        (nrst),
        .lock_evt    ({abn_speed_evt, sync_loss_evt, no_motor_evt}),
        .lock_en     ({cfg_q[ABN_EN_BIT], cfg_q[SYNC_EN_BIT],
                       cfg_q[NOMTR_EN_BIT]}),
        .cause_clear (fault_clear),
        .gated_evt_q (gated_evt_q),
        .cause_q     (lock_cause_q)
    );

    // RULE_17: only gated events act
    assign any_evt    = |gated_evt_q;
    assign timer_done = timer_q == 32'(RETRY_CYCLES - 1);
    assign limit_hit  = retry_limit != 5'h00 &&
                        retry_cnt_q + 5'h01 >= retry_limit;

    // RULE_16: lock response sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            LK_IDLE: begin
                if (any_evt && lock_response_mode < MODE_RETRY_MIN) begin
                    state_d = LK_LATCHED;
                end else if (any_evt && lock_response_mode < MODE_REPORT) begin
                    state_d = LK_RETRY_WAIT;
                end
            end
            LK_LATCHED: begin
                // a new lock in the clear cycle keeps the fault
                if (fault_clear && !any_evt) begin
                    state_d = LK_IDLE;
                end
            end
            LK_RETRY_WAIT: begin
                if (timer_done) begin
                    state_d = limit_hit ? LK_LATCHED : LK_IDLE;
                end
            end
            default: state_d = LK_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= LK_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            timer_q <= 32'h0000_0000;
        end else if (state_q == LK_RETRY_WAIT && !timer_done) begin
            timer_q <= timer_q + 32'h0000_0001;
        end else begin
            timer_q <= 32'h0000_0000;
        end
    end

    // attempts count until a clear with the next state idle, as in a quiet latched exit
    always_ff @(posedge clk) begin
        if (!nrst) begin
            retry_cnt_q <= 5'h00;
        end else if (fault_clear && state_d == LK_IDLE) begin
            retry_cnt_q <= 5'h00;
        end else if (state_q == LK_RETRY_WAIT && timer_done) begin
            retry_cnt_q <= retry_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bridge_action_q <= 2'h0;
            lock_report_q   <= 1'b0;
        end else begin
            if (state_q == LK_IDLE && state_d != LK_IDLE) begin
                bridge_action_q <= lock_response_mode[1:0];
            end
            if (any_evt && lock_response_mode == MODE_REPORT) begin
                lock_report_q <= 1'b1;
            end else if (fault_clear) begin
                lock_report_q <= 1'b0;
            end
        end
    end

    assign ov_now = max_running_supply != 10'h000 &&
                    supply_dv > max_running_supply;
    assign uv_now = min_running_supply != 10'h000 &&
                    supply_dv < min_running_supply;

    // RULE_08: latch or auto clear
    always_comb begin
        if (ov_now) begin
            ov_d = 1'b1;
        end else if (cfg_q[OV_MODE_BIT] || fault_clear) begin
            ov_d = 1'b0;
        end else begin
            ov_d = ov_fault_q;
        end
    end

    // RULE_10: latch or auto clear
    always_comb begin
        if (uv_now) begin
            uv_d = 1'b1;
        end else if (cfg_q[UV_MODE_BIT] || fault_clear) begin
            uv_d = 1'b0;
        end else begin
            uv_d = uv_fault_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ov_fault_q         <= 1'b0;
            uv_fault_q         <= 1'b0;
            lock_fault_q       <= 1'b0;
            fault_output_low_q <= 1'b1;
        end else begin
            ov_fault_q         <= ov_d;
            uv_fault_q         <= uv_d;
            lock_fault_q       <= state_d != LK_IDLE;
            fault_output_low_q <= !((state_d != LK_IDLE) || ov_d || uv_d);
        end
    end

    property p_reset_zero;
        @(posedge clk) !nrst |=> cfg_q == CFG_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) // RULE_01
        else $error("config word not zero after reset");

    property p_rw;
        @(posedge clk) disable iff (!nrst)
        reg_wr && reg_addr == CFG_OFFSET ##1 reg_rd && reg_addr == CFG_OFFSET
        && !reg_wr |=> reg_rvalid_q && reg_rdata_q == $past(reg_wdata, 2);
    endproperty
    a_rw: assert property (p_rw) // RULE_01
        else $error("read back differs from written word");

    property p_abn_thr;
        @(posedge clk) disable iff (!nrst)
        ##1 abnormal_speed_threshold == 12'((16'($past(cfg_q[27:24]))
            + 16'h0001) * 16'h00FA);
    endproperty
    a_abn_thr: assert property (p_abn_thr) // RULE_05
        else $error("abnormal speed threshold decode wrong");

    property p_sync_cnt;
        @(posedge clk) disable iff (!nrst)
        ##1 sync_loss_count == 4'($past(cfg_q[23:21])) + 4'h2;
    endproperty
    a_sync_cnt: assert property (p_sync_cnt) // RULE_06
        else $error("sync loss count decode wrong");

    property p_fault_cause;
        @(posedge clk) disable iff (!nrst)
        $rose(lock_fault_q) |-> $past(any_evt);
    endproperty
    a_fault_cause: assert property (p_fault_cause) // RULE_17
        else $error("lock fault without enabled detector event");

    property p_latched_hold;
        @(posedge clk) disable iff (!nrst)
        state_q == LK_LATCHED && !fault_clear ##1 !fault_clear
        |-> lock_fault_q[*2];
    endproperty
    a_latched_hold: assert property (p_latched_hold) // RULE_16
        else $error("latched lock fault dropped without clear");

    property p_report_only;
        @(posedge clk) disable iff (!nrst)
        state_q == LK_IDLE && any_evt && lock_response_mode == MODE_REPORT
        |=> lock_report_q && !lock_fault_q;
    endproperty
    a_report_only: assert property (p_report_only) // RULE_16
        else $error("report mode misbehaved");

    property p_ov_latch;
        @(posedge clk) disable iff (!nrst)
        ov_fault_q && !cfg_q[17] && !fault_clear |=> ov_fault_q;
    endproperty
    a_ov_latch: assert property (p_ov_latch) // RULE_08
        else $error("latched overvoltage cleared itself");

    property p_uv_auto;
        @(posedge clk) disable iff (!nrst)
        cfg_q[13] && !uv_now |=> !uv_fault_q;
    endproperty
    a_uv_auto: assert property (p_uv_auto) // RULE_10
        else $error("undervoltage did not auto clear");

    property p_fault_pin;
        @(posedge clk) disable iff (!nrst)
        fault_output_low_q == !(lock_fault_q || ov_fault_q || uv_fault_q);
    endproperty
    a_fault_pin: assert property (p_fault_pin) // RULE_16
        else $error("fault output disagrees with faults");

    c_latched: cover property (@(posedge clk) disable iff (!nrst)
        state_q == LK_IDLE ##1 state_q == LK_LATCHED);
    c_retry: cover property (@(posedge clk) disable iff (!nrst)
        state_q == LK_RETRY_WAIT ##1 state_q == LK_IDLE);
    c_ov: cover property (@(posedge clk) disable iff (!nrst)
        $rose(ov_fault_q));
endmodule

// >>> mlsfc_cfg_tb.sv
`timescale 1ns/10ps
module mlsfc_cfg_tb;
    import mlsfc_pkg::*;
    // short retry span keeps the automatic recovery case brief
    localparam int RC = 8;
    typedef struct {
        logic [31:0] word;
        int          exp [9];
    } mlsfc_row_t;
    localparam int NM [8] = '{5000, 7500, 10000, 12500, 20000, 25000,
        30000, 40000};
    localparam int MX [8] = '{0, 200, 250, 300, 350, 400, 500, 600};
    localparam int MN [8] = '{0, 60, 70, 80, 90, 100, 120, 150};
    localparam int RT [8] = '{0, 2, 3, 5, 7, 10, 15, 20};
    localparam int SP [8] = '{5, 10, 20, 30, 50, 100, 150, 250};
    localparam int DT [4] = '{10, 15, 20, 25};
    localparam int DEF [9] = '{250, 2, 5000, 0, 0, 0, 5, 2, 10};

    logic        clk;
    logic        nrst;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata_q;
    logic        reg_rvalid_q;
    logic        abn_speed_evt;
    logic        sync_loss_evt;
    logic        no_motor_evt;
    logic [3:0]  lock_response_mode;
    logic        fault_clear;
    logic [9:0]  supply_dv;
    logic        abnormal_speed_lock_enable;
    logic        sync_loss_lock_enable;
    logic        no_motor_lock_enable;
    logic [11:0] abnormal_speed_threshold;
    logic [3:0]  sync_loss_count;
    logic [15:0] no_motor_current_threshold;
    logic [9:0]  max_running_supply;
    logic [9:0]  min_running_supply;
    logic [4:0]  retry_limit;
    logic [7:0]  min_lock_speed;
    logic [3:0]  speed_jump_ratio;
    logic [4:0]  zero_speed_duty_threshold;
    logic [2:0]  lock_cause_q;
    logic        lock_fault_q;
    logic        lock_report_q;
    logic [1:0]  bridge_action_q;
    logic        ov_fault_q;
    logic        uv_fault_q;
    logic        fault_output_low_q;
    logic [2:0]  ens;
    logic [31:0] seen [9];
    string       fld [9] = '{"thr", "cnt", "nomtr", "maxv", "minv",
        "retry", "minspd", "ratio", "duty"};
    mlsfc_row_t  rows [8];
    int          mismatches = 0;
    int          cmp_count = 0;

    mlsfc_cfg #(.RETRY_CYCLES(RC)) mlsfc_cfg_inst (.clk, .nrst, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .reg_rvalid_q,
        .abn_speed_evt, .sync_loss_evt, .no_motor_evt, .lock_response_mode,
        .fault_clear, .supply_dv, .abnormal_speed_lock_enable,
        .sync_loss_lock_enable, .no_motor_lock_enable,
        .abnormal_speed_threshold, .sync_loss_count,
        .no_motor_current_threshold, .max_running_supply,
        .min_running_supply, .retry_limit, .min_lock_speed,
        .speed_jump_ratio, .zero_speed_duty_threshold, .lock_cause_q,
        .lock_fault_q, .lock_report_q, .bridge_action_q, .ov_fault_q,
        .uv_fault_q, .fault_output_low_q);

    assign seen = '{32'(abnormal_speed_threshold), 32'(sync_loss_count),
        32'(no_motor_current_threshold), 32'(max_running_supply),
        32'(min_running_supply), 32'(retry_limit), 32'(min_lock_speed),
        32'(speed_jump_ratio), 32'(zero_speed_duty_threshold)};
    assign ens = {abnormal_speed_lock_enable, sync_loss_lock_enable,
        no_motor_lock_enable};

    always #2 clk = ~clk;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", 32'(reg_rvalid_q), 32'd1);
        chk("rdata", reg_rdata_q, exp);
    endtask

    // bit order: clear, abnormal speed, sync loss, no motor
    task automatic pulse(logic [3:0] m);
        @(posedge clk);
        {fault_clear, abn_speed_evt, sync_loss_evt, no_motor_evt} <= m;
        @(posedge clk);
        {fault_clear, abn_speed_evt, sync_loss_evt, no_motor_evt} <= 4'h0;
    endtask

    task automatic check_dec(int e [9]);
        for (int j = 0; j < 9; j++) begin
            chk(fld[j], seen[j], 32'(e[j]));
        end
    endtask

    task automatic set_mode(logic [3:0] m);
        @(posedge clk);
        lock_response_mode <= m;
    endtask

    initial begin
        #20000;
        mismatches++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        {reg_wr, reg_rd, fault_clear} = 3'b000;
        {abn_speed_evt, sync_loss_evt, no_motor_evt} = 3'b000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        lock_response_mode = 4'h0;
        supply_dv = 10'h064;
        for (int k = 0; k < 8; k++) begin
            rows[k].word = {1'b1, 3'(k), 4'(2 * k + 1), 3'(k), 3'(k),
                1'(k), 3'(k), 1'(k >> 1), 3'(k), 3'(k), 3'(k), 2'(k),
                2'(3 - k)};
            rows[k].exp = '{250 * (2 * k + 2), k + 2, NM[k], MX[k], MN[k],
                RT[k], SP[k], 2 * (k % 4) + 2, DT[(7 - k) % 4]};
        end
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(CFG_OFFSET, rows[k].word);
            tick(2);
            check_dec(rows[k].exp);
            chk("enables", 32'(ens), 32'(k));
            rd(CFG_OFFSET, rows[k].word);
        end
        // mid-run reset must restore every field
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        check_dec(DEF);
        chk("fault_low", 32'(fault_output_low_q), 32'd1);
        rd(CFG_OFFSET, 32'h0000_0000);
        wr(8'h96, 32'hFFFF_FFFF);
        rd(CFG_OFFSET, 32'h0000_0000);
        rd(8'h96, 32'h0000_0000);
        // write then read back to back
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= CFG_OFFSET;
        reg_wdata <= 32'h0000_0155;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("b2b_valid", 32'(reg_rvalid_q), 32'd1);
        chk("b2b_data", reg_rdata_q, 32'h0000_0155);
        wr(CFG_OFFSET, 32'h4000_0000);
        pulse(4'b0010);
        tick(3);
        chk("dis_fault", 32'(lock_fault_q), 32'd0);
        chk("dis_low", 32'(fault_output_low_q), 32'd1);
        chk("dis_cause", 32'(lock_cause_q), 32'd0);
        for (int m = 0; m < 4; m++) begin
            set_mode(4'(m));
            pulse(4'b0100);
            tick(2);
            chk("lock", 32'(lock_fault_q), 32'd1);
            chk("low", 32'(fault_output_low_q), 32'd0);
            chk("bridge", 32'(bridge_action_q), 32'(m));
            chk("cause", 32'(lock_cause_q), 32'h4);
            tick(4);
            chk("held", 32'(lock_fault_q), 32'd1);
            pulse(4'b1000);
            tick(1);
            chk("cleared", 32'(lock_fault_q), 32'd0);
            chk("clr_low", 32'(fault_output_low_q), 32'd1);
        end
        wr(CFG_OFFSET, 32'h2000_0000);
        set_mode(4'h8);
        pulse(4'b0110);
        tick(2);
        chk("report", 32'({lock_report_q, lock_fault_q}), 32'h2);
        chk("rep_low", 32'(fault_output_low_q), 32'd1);
        chk("rep_cause", 32'(lock_cause_q), 32'h2);
        pulse(4'b1000);
        wr(CFG_OFFSET, 32'h1000_0000);
        set_mode(4'h9);
        pulse(4'b0001);
        tick(2);
        chk("off", 32'({lock_report_q, lock_fault_q}), 32'd0);
        set_mode(4'h4);
        pulse(4'b0001);
        tick(2);
        chk("retry", 32'(lock_fault_q), 32'd1);
        tick(RC + 3);
        chk("recover", 32'(lock_fault_q), 32'd0);
        pulse(4'b1000);
        // limit of two attempts then latch
        wr(CFG_OFFSET, 32'h1000_0080);
        pulse(4'b0001);
        tick(RC + 3);
        chk("try1", 32'(lock_fault_q), 32'd0);
        pulse(4'b0001);
        tick(RC + 3);
        chk("try_latch", 32'(lock_fault_q), 32'd1);
        pulse(4'b1000);
        // max 20 V latched, min 6 V auto-clear
        wr(CFG_OFFSET, 32'h0000_6400);
        @(posedge clk);
        supply_dv <= 10'd201;
        tick(2);
        chk("ov", 32'(ov_fault_q), 32'd1);
        @(posedge clk);
        supply_dv <= 10'd200;
        tick(3);
        chk("ov_latch", 32'(ov_fault_q), 32'd1);
        pulse(4'b1000);
        tick(1);
        chk("ov_clr", 32'(ov_fault_q), 32'd0);
        @(posedge clk);
        supply_dv <= 10'd59;
        tick(2);
        chk("uv", 32'(uv_fault_q), 32'd1);
        @(posedge clk);
        supply_dv <= 10'd60;
        tick(3);
        chk("uv_auto", 32'(uv_fault_q), 32'd0);
        wr(CFG_OFFSET, 32'h0000_0000);
        @(posedge clk);
        supply_dv <= 10'h3FF;
        tick(3);
        chk("no_max", 32'(ov_fault_q), 32'd0);
        chk("no_min", 32'(uv_fault_q), 32'd0);
        give_verdict();
    end
endmodule
